// >>> rtl/conv_port_pkg.sv
// package: constants, states and carriers for the converter port block
package conv_port_pkg;
  localparam int DATA_W        = 12;
  localparam int BYTE_W        = 8;
  localparam int CHAN_W        = 2;
  localparam int CTRL_W        = 12;
  // conversion clock periods per conversion
  localparam logic [3:0] CONV_CLOCKS = 4'hD;
  // fixed extra delay after the last conversion clock edge, in ns
  localparam int EXTRA_NS      = 20;
  localparam int CLK_NS        = 4;
  localparam logic [3:0] EXTRA_CYC =
    4'((EXTRA_NS + CLK_NS - 1) / CLK_NS);
  // control register fields used by this block
  localparam int CHAN_LSB      = 0;
  localparam int PWR_LSB       = 2;
  localparam logic [1:0] PWR_NORMAL    = 2'h0;
  localparam logic [1:0] PWR_AUTO_SHDN = 2'h1;
  localparam logic [1:0] PWR_AUTO_STBY = 2'h2;
  localparam logic [1:0] PWR_FULL_SHDN = 2'h3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam int HI_NIBBLE_W   = 4;
  localparam int CHAN_POS      = 4;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV  = 2'b01,
    ST_TAIL  = 2'b10,
    ST_SLEEP = 2'b11
  } conv_state_t;

  // host side bus strobes, active low, plus the word mode select, high for word mode
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic word_mode;
  } bus_ctl_t;

  // latched result with its channel
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] code;
  } result_t;
endpackage

// >>> rtl/edge_detect.sv
// edge detector for the conversion start and conversion clock pins
`timescale 1ns/1ps
module edge_detect (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // sampled level and its edges
  input  wire logic level_in,
  output logic      rise,
  output logic      fall
);
  logic prev_reg;
  logic prev_next;

  // previous level; reset to high since both pins idle high
  always_comb begin
    prev_next = level_in;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = level_in & ~prev_reg;
  assign fall = ~level_in & prev_reg;
endmodule // edge_detect

// >>> rtl/conv_port_ctrl.sv
// converter control and parallel data port, word and byte modes
//
// How it works
// - word select high moves full 12-bit words on all data lines.
// - word select low uses byte mode; pin 8 becomes high byte select.
// - in word mode the shared pin is data bit 8, three-state.
// - byte mode, high select low: low byte on lower eight lines.
// - byte mode, high select high: top four bits on lines 0 to 3.
// - high byte read puts channel on lines 4-5, zeros on 6-7.
// - lower lines are three-state, read results, take control writes.
// - lines 9 to 11 carry data only in word mode.
// - busy rises after start falls and stays high through conversion.
// - busy falls only once the result sits in the output register.
// - sampler returns to track on the thirteenth conversion clock rise.
// - conversion takes thirteen conversion clocks plus a fixed delay.
// - conversion clock may run continuously or only in bursts.
// - start falling edge moves sampler to hold and begins conversion.
// - in auto shutdown or standby, start rising edge wakes the device.
// - write strobe low with chip select loads the control register.
// - read strobe low with chip select drives the result onto the bus.
`timescale 1ns/1ps
module conv_port_ctrl (
  // clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             nrst,
  // host strobes and mode select
  input  wire conv_port_pkg::bus_ctl_t          bus_ctl,
  // lower data lines, three signals each
  input  wire logic [conv_port_pkg::BYTE_W-1:0] lower_data_lines_in,
  output logic [conv_port_pkg::BYTE_W-1:0]      lower_data_lines_out,
  output logic [conv_port_pkg::BYTE_W-1:0]      lower_data_lines_oe_n,
  // shared data bit 8 or high byte select pin
  input  wire logic                             data8_or_high_byte_pin_in,
  output logic                                  data8_or_high_byte_pin_out,
  output logic                                  data8_or_high_byte_pin_oe_n,
  // upper data lines 9 to 11
  input  wire logic [2:0]                       upper_data_lines_in,
  output logic [2:0]                            upper_data_lines_out,
  output logic [2:0]                            upper_data_lines_oe_n,
  // conversion control
  input  wire logic                             conversion_start_n,
  input  wire logic                             conversion_clock_input,
  output logic                                  busy,
  // analog core side: sample hold, quantiser code and channel
  input  wire logic [conv_port_pkg::DATA_W-1:0] core_code,
  output logic                                  hold,
  output logic                                  powered_up,
  output logic [conv_port_pkg::CTRL_W-1:0]      ctrl_value
);
  import conv_port_pkg::*;

  conv_state_t        state_reg,  state_next;
  logic [3:0]         cnt_reg,    cnt_next;
  result_t            result_reg, result_next;
  logic [CTRL_W-1:0]  ctrl_reg,   ctrl_next;
  logic [CHAN_W-1:0]  chan_reg,   chan_next;
  logic               wr_prev_reg, wr_prev_next;
  logic [DATA_W-1:0]  rd_bus_reg, rd_bus_next;
  logic               start_rise, start_fall, cclk_rise;
  logic               wr_act, rd_act, high_sel, drive_en;
  logic [DATA_W-1:0]  bus_in;
  logic [1:0]         pwr_mode;

  // edges of the start pin and the conversion clock pin
  edge_detect u_start (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .level_in (conversion_start_n),
    .rise     (start_rise),
    .fall     (start_fall)
  );

  // burst or free running clock both work: only edges inside a
  // conversion are counted
  edge_detect u_cclk (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .level_in (conversion_clock_input),
    .rise     (cclk_rise),
    .fall     ()
  );

  // shared pin is high byte select only in byte mode
  assign high_sel = ~bus_ctl.word_mode & data8_or_high_byte_pin_in;
  assign wr_act   = ~bus_ctl.cs_n & ~bus_ctl.wr_n;
  assign rd_act   = ~bus_ctl.cs_n & ~bus_ctl.rd_n;
  assign pwr_mode = ctrl_reg[PWR_LSB +: 2];

  // assemble a write value from the pins as the mode dictates
  always_comb begin
    bus_in = ctrl_reg;
    if (bus_ctl.word_mode) begin
      bus_in = {upper_data_lines_in, data8_or_high_byte_pin_in,
                lower_data_lines_in};
    end else if (high_sel) begin
      // only the top nibble is taken; lines 4-7 are ignored
      bus_in[DATA_W-1 -: HI_NIBBLE_W] =
        lower_data_lines_in[HI_NIBBLE_W-1:0];
    end else begin
      bus_in[BYTE_W-1:0] = lower_data_lines_in;
    end
  end

  // control register: loaded once per write strobe, on its trailing edge
  always_comb begin
    wr_prev_next = wr_act;
    ctrl_next    = ctrl_reg;
    if (wr_prev_reg && !wr_act) begin
      ctrl_next = bus_in;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_prev_reg <= 1'b0;
      ctrl_reg    <= CTRL_RESET;
    end else begin
      wr_prev_reg <= wr_prev_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // conversion sequencer
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    result_next = result_reg;
    chan_next   = chan_reg;
    case (state_reg)
      ST_TRACK: begin
        if (start_fall) begin
          // hold the sample and start counting clocks
          state_next = ST_CONV;
          cnt_next   = 4'h0;
          chan_next  = ctrl_reg[CHAN_LSB +: CHAN_W];
        end
      end
      ST_CONV: begin
        if (cclk_rise) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg + 4'h1 == CONV_CLOCKS) begin
            // thirteenth edge: sampler back to track, result latched
            state_next  = ST_TAIL;
            cnt_next    = 4'h0;
            result_next = '{chan: chan_reg, code: core_code};
          end
        end
      end
      ST_TAIL: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg + 4'h1 >= EXTRA_CYC) begin
          // auto shutdown and auto standby modes sleep after each conversion
          if (pwr_mode == PWR_AUTO_SHDN || pwr_mode == PWR_AUTO_STBY) begin
            state_next = ST_SLEEP;
          end else begin
            state_next = ST_TRACK;
          end
        end
      end
      ST_SLEEP: begin
        if (start_rise) begin
          state_next = ST_TRACK;
        end
      end
      default: begin
        state_next = ST_TRACK;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= ST_TRACK;
      cnt_reg    <= 4'h0;
      result_reg <= '0;
      chan_reg   <= '0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      result_reg <= result_next;
      chan_reg   <= chan_next;
    end
  end

  // busy covers counting and the fixed tail, so it drops after latch
  assign busy       = (state_reg == ST_CONV) ||
                      (state_reg == ST_TAIL);
  assign hold       = (state_reg == ST_CONV);
  assign powered_up = (state_reg != ST_SLEEP) &&
                      (pwr_mode != PWR_FULL_SHDN);
  assign ctrl_value = ctrl_reg;

  // read data register chosen by mode and byte select
  always_comb begin
    rd_bus_next = '0;
    if (bus_ctl.word_mode) begin
      rd_bus_next = result_reg.code;
    end else if (high_sel) begin
      rd_bus_next[HI_NIBBLE_W-1:0] =
        result_reg.code[DATA_W-1 -: HI_NIBBLE_W];
      rd_bus_next[CHAN_POS +: CHAN_W] = result_reg.chan;
    end else begin
      rd_bus_next[BYTE_W-1:0] = result_reg.code[BYTE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_bus_reg <= '0;
    end else begin
      rd_bus_reg <= rd_bus_next;
    end
  end

  // drivers float when not read; upper pins float in byte mode too
  assign drive_en = rd_act;
  assign lower_data_lines_out  = rd_bus_reg[BYTE_W-1:0];
  assign lower_data_lines_oe_n = {BYTE_W{~drive_en}};
  assign data8_or_high_byte_pin_out  = rd_bus_reg[BYTE_W];
  assign data8_or_high_byte_pin_oe_n =
    ~(drive_en & bus_ctl.word_mode);
  assign upper_data_lines_out  = rd_bus_reg[DATA_W-1:BYTE_W+1];
  assign upper_data_lines_oe_n =
    {(DATA_W-BYTE_W-1){~(drive_en & bus_ctl.word_mode)}};

  // checks
  busy_after_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == ST_TRACK && start_fall) |=> busy)
    else $error("busy did not rise after start fell");
  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (busy && state_reg == ST_CONV) |=> busy)
    else $error("busy dropped mid conversion");
  busy_result_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(busy) |-> $past(state_reg) == ST_TAIL)
    else $error("busy fell before result latched");
  track_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == ST_CONV && cclk_rise && cnt_reg == CONV_CLOCKS - 4'h1) |=>
      (!hold && busy))
    else $error("sampler not back to track on edge thirteen");
  conv_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == ST_CONV && cclk_rise && cnt_reg == CONV_CLOCKS - 4'h1) |=>
      busy [*5] ##1 !busy)
    else $error("conversion tail length wrong");
  hold_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == ST_TRACK && start_fall) |=> hold)
    else $error("sampler not held after start");
  wake_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_reg == ST_SLEEP && start_rise) |=> powered_up ||
      pwr_mode == PWR_FULL_SHDN)
    else $error("no wake on start rise");
  ctrl_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(wr_act) && bus_ctl.word_mode && !$past(bus_ctl.cs_n)
      |=> ctrl_reg == $past(bus_in))
    else $error("control register not loaded");
  float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bus_ctl.cs_n || bus_ctl.rd_n) |-> (&lower_data_lines_oe_n &&
      data8_or_high_byte_pin_oe_n && &upper_data_lines_oe_n))
    else $error("bus driven without read");
  byte_hi_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd_act && high_sel && $stable(high_sel) && $stable(result_reg))
      |-> lower_data_lines_out[BYTE_W-1:CHAN_POS+CHAN_W] == '0 &&
          lower_data_lines_out[CHAN_POS +: CHAN_W] == result_reg.chan)
    else $error("high byte read layout wrong");
endmodule // conv_port_ctrl

// >>> dv/host_bus.sv
// host side model: drives strobes and data, resolves the shared data wires
`timescale 1ns/1ps
module host_bus (
  // clock
  input  wire logic                clk_sys,
  // strobes and resolved wires seen by the device
  output conv_port_pkg::bus_ctl_t  bus_ctl,
  output logic [11:0]              bus_w,
  // device drive and enables, all twelve lines
  input  wire logic [11:0]         dev_out,
  input  wire logic [11:0]         dev_oe_n
);
  logic [11:0] drv;
  logic [11:0] den;
  logic        junk;

  initial begin
    bus_ctl = '{1'h1, 1'h1, 1'h1, 1'h1};
    drv = 12'h000;
    den = 12'h000;
    junk = 1'h0;
  end

  // a floating line toggles every cycle so a stale value never looks right
  always @(posedge clk_sys) junk <= ~junk;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      bus_w[i] = !dev_oe_n[i] ? dev_out[i] : den[i] ? drv[i] : junk;
    end
  end

  // write: strobes low one cycle, data held one cycle past the strobe end
  task automatic bus_wr(input logic word, input logic hi,
                        input logic [11:0] d);
    @(posedge clk_sys);
    bus_ctl <= '{1'h0, 1'h1, 1'h0, word};
    drv <= word ? d : {3'h0, hi, d[7:0]};
    den <= word ? 12'hFFF : 12'h1FF;
    @(posedge clk_sys);
    bus_ctl <= '{1'h1, 1'h1, 1'h1, word};
    @(posedge clk_sys);
    den <= word ? 12'h000 : 12'h100;
  endtask

  // read: select set with the strobes, data taken two edges later
  task automatic bus_rd(input logic word, input logic hi,
                        output logic [11:0] q, output logic [11:0] oe);
    @(posedge clk_sys);
    bus_ctl <= '{1'h0, 1'h0, 1'h1, word};
    drv <= {3'h0, hi, 8'h00};
    den <= word ? 12'h000 : 12'h100;
    repeat (2) @(posedge clk_sys);
    #1;
    q = bus_w;
    oe = dev_oe_n;
    @(posedge clk_sys);
    bus_ctl <= '{1'h1, 1'h1, 1'h1, word};
  endtask
endmodule // host_bus

// >>> dv/tb.sv
// testbench for the converter control and parallel port block
`timescale 1ns/1ps
module tb;
  import conv_port_pkg::*;
  logic                     clk_sys = 1'h0;
  logic                     nrst = 1'h0;
  logic                     conversion_start_n = 1'h1;
  logic                     conversion_clock_input = 1'h1;
  logic [DATA_W-1:0]        core_code = 12'h000;
  bus_ctl_t                 bus_ctl;
  logic [11:0]              bus_w, q, oe;
  // each group of device pins drives its own slice of these nets
  wire logic [11:0]         dev_out, dev_oe_n;
  logic                     busy, hold, powered_up;
  logic [CTRL_W-1:0]        ctrl_value;
  int                       fails = 0;
  int                       checks_done = 0;
  int                       cycles = 0;

  always #2 clk_sys = ~clk_sys;

  host_bus host (.clk_sys(clk_sys), .bus_ctl(bus_ctl), .bus_w(bus_w),
    .dev_out(dev_out), .dev_oe_n(dev_oe_n));
  conv_port_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .bus_ctl(bus_ctl),
    .lower_data_lines_in(bus_w[7:0]),
    .lower_data_lines_out(dev_out[7:0]),
    .lower_data_lines_oe_n(dev_oe_n[7:0]),
    .data8_or_high_byte_pin_in(bus_w[8]),
    .data8_or_high_byte_pin_out(dev_out[8]),
    .data8_or_high_byte_pin_oe_n(dev_oe_n[8]),
    .upper_data_lines_in(bus_w[11:9]),
    .upper_data_lines_out(dev_out[11:9]),
    .upper_data_lines_oe_n(dev_oe_n[11:9]),
    .conversion_start_n(conversion_start_n),
    .conversion_clock_input(conversion_clock_input), .busy(busy),
    .core_code(core_code), .hold(hold), .powered_up(powered_up),
    .ctrl_value(ctrl_value));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // a hang is cut short well past the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      print_verdict();
    end
  end

  // one conversion; the clock stands high between frames unless free is
  // set, then it also runs while tracking and those rises must not count
  task automatic conv(input logic [11:0] code, input logic free);
    int n;
    if (free) begin
      repeat (2) begin
        @(posedge clk_sys) conversion_clock_input <= 1'h0;
        @(posedge clk_sys) conversion_clock_input <= 1'h1;
      end
    end
    @(posedge clk_sys);
    core_code <= code;
    conversion_start_n <= 1'h0;
    n = 0;
    while (busy !== 1'h1 && n < 3) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(12'(n), 12'h001);
    chk(12'({hold, busy}), 12'h003);
    @(posedge clk_sys);
    conversion_start_n <= 1'h1;
    for (int i = 1; i <= 13; i++) begin
      @(posedge clk_sys) conversion_clock_input <= 1'h0;
      repeat (2) @(posedge clk_sys);
      conversion_clock_input <= 1'h1;
      @(posedge clk_sys);
      #1 if (i < 13) chk(12'({hold, busy}), 12'h003);
    end
    // back to track at once, busy still covers the fixed tail
    chk(12'({hold, busy}), 12'h001);
    n = 0;
    while (busy === 1'h1 && n < 20) begin
      @(posedge clk_sys);
      core_code <= ~code;
      #1 n++;
    end
    chk(12'(n), 12'(EXTRA_CYC));
  endtask

  task automatic t_reset();
    chk(dev_oe_n, 12'hFFF);
    chk(12'({busy, hold, powered_up}), 12'h001);
    chk(ctrl_value, CTRL_RESET);
    $display("test reset done");
  endtask

  task automatic t_word();
    host.bus_wr(1'h1, 1'h0, 12'hA51);
    @(posedge clk_sys);
    #1 chk(ctrl_value, 12'hA51);
    conv(12'h5C3, 1'h0);
    host.bus_rd(1'h1, 1'h0, q, oe);
    chk(oe, 12'h000);
    chk(q, 12'h5C3);
    #1 chk(dev_oe_n, 12'hFFF);
    $display("test word done");
  endtask

  task automatic t_byte();
    host.bus_rd(1'h0, 1'h0, q, oe);
    chk(oe, 12'hF00);
    chk(12'(q[7:0]), 12'h0C3);
    host.bus_rd(1'h0, 1'h1, q, oe);
    chk(oe, 12'hF00);
    chk(12'(q[7:0]), 12'h015);
    host.bus_wr(1'h0, 1'h0, 12'h042);
    host.bus_wr(1'h0, 1'h1, 12'h007);
    @(posedge clk_sys);
    #1 chk(ctrl_value, 12'h742);
    $display("test byte done");
  endtask

  // both automatic modes sleep after a conversion and wake on start rising
  task automatic t_sleep();
    for (int m = 1; m <= 2; m++) begin
      host.bus_wr(1'h1, 1'h0, 12'(m << PWR_LSB));
      conv(12'h0FF, 1'h1);
      #1 chk(12'(powered_up), 12'h000);
      @(posedge clk_sys) conversion_start_n <= 1'h0;
      repeat (3) @(posedge clk_sys);
      #1 chk(12'(busy), 12'h000);
      @(posedge clk_sys) conversion_start_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      #1 chk(12'(powered_up), 12'h001);
    end
    host.bus_wr(1'h1, 1'h0, 12'h00C);
    repeat (3) @(posedge clk_sys);
    #1 chk(12'(powered_up), 12'h000);
    host.bus_wr(1'h1, 1'h0, 12'h000);
    $display("test sleep done");
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    #1 t_reset();
    t_word();
    t_byte();
    t_sleep();
    print_verdict();
  end
endmodule // tb
